// ==== rtl/ssp_consts.svh ====
// Offsets, field positions, reset values and timing counts of the serial port.
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
`define SSP_ADDR_W          2
`define SSP_OFF_STATUS      2'h0
`define SSP_OFF_CONTROL     2'h1
`define SSP_OFF_DATA        2'h2
`define SSP_OFF_PINS        2'h3
`define SSP_STAT_SMP        7
`define SSP_STAT_CKE        6
`define SSP_STAT_STOP       4
`define SSP_STAT_BF         0
`define SSP_CTL_WRITE_COLLISION        7
`define SSP_CTL_OV          6
`define SSP_CTL_EN          5
`define SSP_CTL_CKP         4
`define SSP_STATUS_RST      8'h00
`define SSP_CONTROL_RST     8'h00
`define SSP_MODE_DIV4       4'h0
`define SSP_MODE_DIV16      4'h1
`define SSP_MODE_DIV64      4'h2
`define SSP_MODE_SLV_SS     4'h4
`define SSP_MODE_SLV_NOSS   4'h5
`define SSP_HALF_DIV4       6'h01
`define SSP_HALF_DIV16      6'h07
`define SSP_HALF_DIV64      6'h1F
`define SSP_WORD_BITS       4'h8
`endif

// ==== rtl/ssp_pkg.sv ====
// Types shared by the serial port design.
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_IDLE  = 3'b001,
        SSP_LEAD  = 3'b010,
        SSP_TRAIL = 3'b100
    } ssp_state_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ssp_bus_t;

    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic sdo_o;
        logic sdo_oe;
    } ssp_pins_t;

    typedef struct packed {
        logic [1:0]  stat_hi;
        logic        stop;
        logic        bf;
        logic [7:0]  ctl;
        logic [7:0]  buf_q;
        logic [7:0]  sr;
        logic [3:0]  cnt;
        logic [5:0]  div;
        ssp_state_t  st;
        logic [1:0]  sck_s;
        logic [1:0]  sdi_s;
        logic [1:0]  ss_s;
        logic        sck_d;
        logic        in_bit;
        logic [7:0]  rdata;
        logic        irq;
        logic        wake;
        ssp_pins_t   pins;
    } ssp_regs_t;
endpackage

// ==== rtl/ssp_spi_port.sv ====
// SPI serial port with register interface, master clock divider and slave logic.
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module ssp_spi_port (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire ssp_pkg::ssp_bus_t bus,
    output logic [7:0]            rd_data,
    input  wire logic             sck_i,
    input  wire logic             sdi_i,
    input  wire logic             ss_n_i,
    input  wire logic             sdo_dis,
    output ssp_pkg::ssp_pins_t    pins,
    output logic                  port_interrupt_flag,
    output logic                  wake_pulse
);
`include "ssp_consts.svh"

    ssp_pkg::ssp_regs_t r_r;
    ssp_pkg::ssp_regs_t r_nxt;

    // Maps a mode value to the half period count minus one of the master clock.
    function automatic logic [5:0] half_count(input logic [3:0] m);
        if (m == `SSP_MODE_DIV4) begin
            half_count = `SSP_HALF_DIV4;
        end else if (m == `SSP_MODE_DIV16) begin
            half_count = `SSP_HALF_DIV16;
        end else begin
            half_count = `SSP_HALF_DIV64;
        end
    endfunction

    logic       enable;
    logic       clock_polarity;
    logic       cke;
    logic       sample_point;
    logic [3:0] mode;
    logic       is_master;
    logic       is_slave;
    logic       ss_used;
    logic       ss_high;
    logic       busy;
    logic       sck_lvl;
    logic       launch_lvl;
    logic       ext_launch;
    logic       ext_latch;
    logic       wr_data;
    logic [7:0] shifted;

    // Decoded control fields and slave clock edge detection on synchronised pins.
    always_comb begin
        enable     = r_r.ctl[`SSP_CTL_EN];
        clock_polarity        = r_r.ctl[`SSP_CTL_CKP];
        cke        = r_r.stat_hi[0];
        sample_point        = r_r.stat_hi[1];
        mode       = r_r.ctl[3:0];
        is_master  = enable && (mode == `SSP_MODE_DIV4 || mode == `SSP_MODE_DIV16
                     || mode == `SSP_MODE_DIV64);
        is_slave   = enable && (mode == `SSP_MODE_SLV_SS
                     || mode == `SSP_MODE_SLV_NOSS);
        ss_used    = is_slave && (mode == `SSP_MODE_SLV_SS);
        ss_high    = ss_used && r_r.ss_s[1];
        busy       = is_master && (r_r.st != ssp_pkg::SSP_IDLE);
        sck_lvl    = r_r.sck_s[1];
        // Launch edge is the one back to idle when the edge bit is clear.
        launch_lvl = clock_polarity ^ cke;
        ext_launch = is_slave && !ss_high && (sck_lvl != r_r.sck_d)
                     && (sck_lvl == launch_lvl) && (r_r.cnt != 4'h0 || !cke);
        ext_latch  = is_slave && !ss_high && (sck_lvl != r_r.sck_d)
                     && (sck_lvl != launch_lvl);
        wr_data    = bus.wr && (bus.addr == `SSP_OFF_DATA);
        shifted    = {r_r.sr[6:0], r_r.in_bit};
    end

    // Next-state logic for the whole port.
    always_comb begin
        r_nxt            = r_r;
        r_nxt.irq        = 1'b0;
        r_nxt.wake       = 1'b0;
        r_nxt.sck_s      = {r_r.sck_s[0], sck_i};
        r_nxt.sdi_s      = {r_r.sdi_s[0], sdi_i};
        r_nxt.ss_s       = {r_r.ss_s[0], ss_n_i};
        r_nxt.sck_d      = r_r.sck_s[1];
        r_nxt.rdata      = 8'h00;

        // Register reads, with data read clearing the full bit.
        if (bus.rd) begin
            if (bus.addr == `SSP_OFF_STATUS) begin
                r_nxt.rdata = {r_r.stat_hi, 1'b0, r_r.stop, 3'h0, r_r.bf};
            end else if (bus.addr == `SSP_OFF_CONTROL) begin
                r_nxt.rdata = r_r.ctl;
            end else if (bus.addr == `SSP_OFF_DATA) begin
                r_nxt.rdata = r_r.buf_q;
                r_nxt.bf    = 1'b0;
            end else begin
                r_nxt.rdata = {4'h0, r_r.st == ssp_pkg::SSP_IDLE, r_r.cnt[2:0]};
            end
        end

        // Register writes.
        if (bus.wr) begin
            if (bus.addr == `SSP_OFF_STATUS) begin
                r_nxt.stat_hi = bus.wdata[7:6];
            end else if (bus.addr == `SSP_OFF_CONTROL) begin
                r_nxt.ctl = bus.wdata;
                if (!bus.wdata[`SSP_CTL_EN]) begin
                    r_nxt.stop = 1'b0;
                end
            end
        end

        // Data write while enabled either collides or loads buffer and shifter at once.
        if (wr_data && enable) begin
            if (busy || (is_slave && r_r.cnt != 4'h0)) begin
                r_nxt.ctl[`SSP_CTL_WRITE_COLLISION] = 1'b1;
            end else begin
                r_nxt.buf_q = bus.wdata;
                r_nxt.sr    = bus.wdata;
                r_nxt.cnt   = 4'h0;
                if (is_master) begin
                    r_nxt.st  = ssp_pkg::SSP_LEAD;
                    r_nxt.div = half_count(mode);
                    r_nxt.pins.sdo_o = bus.wdata[7];
                end else if (cke) begin
                    r_nxt.pins.sdo_o = bus.wdata[7];
                end
            end
        end

        // Master engine: two half periods per bit, sample mid or at end.
        if (busy) begin
            if (r_r.div != 6'h00) begin
                r_nxt.div = r_r.div - 6'h01;
            end else begin
                r_nxt.div = half_count(mode);
                case (r_r.st)
                    ssp_pkg::SSP_LEAD: begin
                        r_nxt.st          = ssp_pkg::SSP_TRAIL;
                        r_nxt.pins.sck_o  = ~clock_polarity;
                        if (!sample_point) begin
                            r_nxt.in_bit = r_r.sdi_s[1];
                        end
                        // Edge bit set launches on the edge leaving idle.
                        if (cke && r_r.cnt != 4'h0) begin
                            r_nxt.pins.sdo_o = r_r.sr[7];
                        end
                    end
                    ssp_pkg::SSP_TRAIL: begin
                        r_nxt.pins.sck_o = clock_polarity;
                        r_nxt.sr  = {r_r.sr[6:0], sample_point ? r_r.sdi_s[1] : r_r.in_bit};
                        r_nxt.cnt = r_r.cnt + 4'h1;
                        if (r_r.cnt == `SSP_WORD_BITS - 4'h1) begin
                            r_nxt.st     = ssp_pkg::SSP_IDLE;
                            r_nxt.cnt    = 4'h0;
                            r_nxt.buf_q  = {r_r.sr[6:0], sample_point ? r_r.sdi_s[1] : r_r.in_bit};
                            r_nxt.bf     = 1'b1;
                            r_nxt.irq    = 1'b1;
                        end else begin
                            r_nxt.st = ssp_pkg::SSP_LEAD;
                            // Edge bit clear launches on the edge back to idle.
                            if (!cke) begin
                                r_nxt.pins.sdo_o = r_r.sr[6];
                            end
                        end
                    end
                    default: begin
                        r_nxt.st = ssp_pkg::SSP_IDLE;
                    end
                endcase
            end
        end

        // Slave engine: latch on one edge, launch on the other.
        if (ext_launch) begin
            r_nxt.pins.sdo_o = (r_r.cnt == 4'h0 && !cke) ? r_r.sr[7] : r_r.sr[7];
        end
        if (ext_latch) begin
            r_nxt.sr  = {r_r.sr[6:0], r_r.sdi_s[1]};
            r_nxt.cnt = r_r.cnt + 4'h1;
            if (r_r.cnt == `SSP_WORD_BITS - 4'h1) begin
                r_nxt.cnt  = 4'h0;
                r_nxt.irq  = 1'b1;
                r_nxt.wake = 1'b1;
                if (r_r.bf) begin
                    r_nxt.ctl[`SSP_CTL_OV] = 1'b1;
                end else begin
                    r_nxt.buf_q = {r_r.sr[6:0], r_r.sdi_s[1]};
                    r_nxt.bf    = 1'b1;
                end
            end else if (cke) begin
                r_nxt.pins.sdo_o = r_r.sr[6];
            end
        end
        if (ext_launch && r_r.cnt != 4'h0) begin
            r_nxt.pins.sdo_o = r_r.sr[7];
        end

        // Disable or select released: counter to zero and engine stopped.
        if (!enable || ss_high) begin
            r_nxt.cnt = 4'h0;
            r_nxt.st  = ssp_pkg::SSP_IDLE;
        end
        if (!enable) begin
            r_nxt.stop = 1'b0;
        end

        // Pin ownership follows enable, mode, select and the output disable.
        r_nxt.pins.sck_oe = r_nxt.ctl[`SSP_CTL_EN] && is_master;
        if (r_nxt.st == ssp_pkg::SSP_IDLE && is_master) begin
            r_nxt.pins.sck_o = clock_polarity;
        end
        r_nxt.pins.sdo_oe = enable && !sdo_dis && !ss_high;
    end

    // State register.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r_r         <= '0;
            r_r.st      <= ssp_pkg::SSP_IDLE;
            r_r.ctl     <= `SSP_CONTROL_RST;
            r_r.ss_s    <= 2'b11;
        end else begin
            r_r <= r_nxt;
        end
    end

    // Outputs straight from the state register.
    always_comb begin
        rd_data             = r_r.rdata;
        pins                = r_r.pins;
        port_interrupt_flag = r_r.irq;
        wake_pulse          = r_r.wake;
    end
endmodule

// ==== tb/ssp_far_dev.sv ====
// Far-side serial device: answers as slave, or clocks words in as master.
`timescale 1ns/1ps
module ssp_far_dev #(
    parameter int HALF_NS = 160
) (
    input  wire logic msck,
    input  wire logic msdo,
    output logic      ssck,
    output logic      sdi
);
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    int         left;
    // Starts idle with the clock low.
    initial begin
        ssck = 1'b0;
        sdi = 1'b0;
        left = 0;
    end
    // Latches the design's bit on the rising edge.
    always @(posedge msck) begin
        rx_r = {rx_r[6:0], msdo};
    end
    // Launches the next bit on the falling edge; after the word the line wanders.
    always @(negedge msck) begin
        if (left > 1) begin
            tx_r = {tx_r[6:0], 1'b0};
            sdi = tx_r[7];
            left--;
        end else begin
            sdi = ~sdi;
            left = 0;
        end
    end
    // Prepares the word returned in the next master transfer.
    task arm(input logic [7:0] b);
        tx_r = b;
        sdi = b[7];
        left = 8;
    endtask
    // Clocks n bits of b into the design, most significant first.
    task send(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            sdi = b[i];
            #(HALF_NS) ssck = 1'b1;
            #(HALF_NS) ssck = 1'b0;
        end
        sdi = ~sdi;
    endtask
endmodule

// ==== tb/ssp_spi_port_sva.sv ====
// Concurrent checks on the serial port outputs.
`timescale 1ns/1ps
module ssp_spi_port_sva (
    input wire logic               clk,
    input wire logic               rst,
    input wire ssp_pkg::ssp_bus_t  bus,
    input wire logic               ss_n_i,
    input wire ssp_pkg::ssp_pins_t pins,
    input wire logic               port_interrupt_flag,
    input wire logic               wake_pulse,
    input wire logic [7:0]         rd_data
);
    logic [7:0] ctl_r;
    logic       mst;
    logic       slv;
    // Mirrors the last control word written by software.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_r <= 8'h00;
        end else if (bus.wr && bus.addr == 2'h1) begin
            ctl_r <= bus.wdata;
        end
    end
    assign mst = ctl_r[5] && ctl_r[3:0] < 4'h3;
    assign slv = ctl_r[5] && ctl_r[3:1] == 3'h2;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // A status write followed at once by a status read.
    sequence stat_wr_rd;
        bus.wr && bus.addr == 2'h0 ##1 bus.rd && bus.addr == 2'h0;
    endsequence
    AST_FLAG_PULSE: assert property (port_interrupt_flag |=> !port_interrupt_flag)
        else $error("flag longer than one cycle");
    AST_WAKE_FLAG: assert property (wake_pulse |-> port_interrupt_flag)
        else $error("wake without flag");
    AST_DISABLE_PINS: assert property (bus.wr && bus.addr == 2'h1 && !bus.wdata[5]
        |-> ##[1:3] !pins.sck_oe && !pins.sdo_oe) else $error("pins kept after disable");
    AST_START_CLOCK: assert property (bus.wr && bus.addr == 2'h2 && mst
        |-> ##[1:40] pins.sck_o != ctl_r[4]) else $error("no clock after data write");
    AST_STAT_WRITE: assert property (stat_wr_rd |=> rd_data[7:6] == $past(bus.wdata[7:6], 2))
        else $error("status upper bits lost");
    AST_SS_RELEASE: assert property ((ctl_r[5:0] == 6'h24 && ss_n_i) [*5] |-> !pins.sdo_oe)
        else $error("data out driven while deselected");
    AST_SLAVE_CLK: assert property (slv [*3] |-> !pins.sck_oe)
        else $error("clock driven in slave mode");
    AST_MASTER_CLK: assert property (mst [*3] |-> pins.sck_oe)
        else $error("clock not driven in master mode");
endmodule
bind ssp_spi_port ssp_spi_port_sva chk_i (.clk(clk), .rst(rst), .bus(bus), .ss_n_i(ss_n_i),
    .pins(pins), .port_interrupt_flag(port_interrupt_flag), .wake_pulse(wake_pulse),
    .rd_data(rd_data));

// ==== tb/ssp_spi_port_tb.sv ====
// Self-checking bench for the serial port.
`timescale 1ns/1ps
module ssp_spi_port_tb;
    logic               clk;
    logic               rst;
    ssp_pkg::ssp_bus_t  bus;
    ssp_pkg::ssp_pins_t pins;
    logic [7:0]         rd_data;
    logic               sck_i;
    logic               sdi_i;
    logic               ss_n_i;
    logic               sdo_dis;
    logic               irq;
    logic               wake;
    logic [15:0]        lfsr_r;
    logic [7:0]         exp_q[$];
    logic               rd_seen = 1'b0;
    int                 n;
    int                 t;
    int                 mismatches = 0;
    int                 comparisons = 0;
    ssp_spi_port uut (.clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data), .sck_i(sck_i),
        .sdi_i(sdi_i), .ss_n_i(ss_n_i), .sdo_dis(sdo_dis), .pins(pins),
        .port_interrupt_flag(irq), .wake_pulse(wake));
    ssp_far_dev far (.msck(pins.sck_o), .msdo(pins.sdo_o), .ssck(sck_i), .sdi(sdi_i));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task op(input logic [1:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge clk);
        bus <= '{a, d, w, r};
    endtask
    task rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(a, 8'h00, 1'b0, 1'b1);
    endtask
    task idle;
        op(2'h0, 8'h00, 1'b0, 1'b0);
    endtask
    task wait_irq;
        for (n = 0; irq !== 1'b1 && n < 3000; n++) @(negedge clk);
    endtask
    task finish_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Clock of 20 ns period.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Compares each read answer, in the cycle after the strobe, with the oldest note.
    always @(negedge clk) begin
        if (rd_seen) chk(rd_data, exp_q.pop_front());
        rd_seen = bus.rd;
    end
    // Cuts a hung run short.
    initial begin
        #500000;
        mismatches++;
        finish_test;
    end
    // Main sequence: registers, three master rates, slave overrun, deselect, disable.
    initial begin
        rst = 1'b1;
        bus = '0;
        sdo_dis = 1'b0;
        ss_n_i = 1'b1;
        lfsr_r = 16'h54FF;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        op(2'h0, 8'hFF, 1'b1, 1'b0);
        rd(2'h0, 8'hC0);
        op(2'h0, 8'h80, 1'b1, 1'b0);
        for (int m = 0; m < 3; m++) begin
            lfsr_r = lfsr(lfsr_r);
            t = 32 << (2 * m);
            op(2'h1, 8'h00, 1'b1, 1'b0);
            op(2'h1, 8'h20 | 8'(m), 1'b1, 1'b0);
            sdo_dis <= (m == 2);
            far.arm(lfsr_r[15:8]);
            op(2'h2, lfsr_r[7:0], 1'b1, 1'b0);
            op(2'h2, 8'h5A, 1'b1, 1'b0);
            idle;
            wait_irq;
            chk({7'h00, n >= t - 2 && n <= t + 2}, 8'h01);
            chk({7'h00, wake}, 8'h00);
            chk({7'h00, pins.sdo_oe}, {7'h00, m != 2});
            if (m < 2) chk(far.rx_r, lfsr_r[7:0]);
            rd(2'h0, 8'h81);
            rd(2'h1, 8'hA0 | 8'(m));
            rd(2'h2, lfsr_r[15:8]);
            rd(2'h0, 8'h80);
        end
        op(2'h1, 8'h00, 1'b1, 1'b0);
        op(2'h0, 8'h00, 1'b1, 1'b0);
        op(2'h1, 8'h24, 1'b1, 1'b0);
        idle;
        sdo_dis <= 1'b0;
        ss_n_i <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            lfsr_r = lfsr(lfsr_r);
            fork
                far.send(lfsr_r[7:0], 8);
                begin
                    wait_irq;
                    chk({7'h00, wake}, 8'h01);
                end
            join
        end
        rd(2'h1, 8'h64);
        rd(2'h2, lfsr_r[8:1]);
        rd(2'h0, 8'h00);
        idle;
        far.send(8'hFF, 4);
        @(posedge clk) ss_n_i <= 1'b1;
        repeat (8) @(posedge clk);
        chk({7'h00, pins.sdo_oe}, 8'h00);
        ss_n_i <= 1'b0;
        op(2'h1, 8'h24, 1'b1, 1'b0);
        idle;
        fork
            far.send(8'hC3, 8);
            wait_irq;
        join
        rd(2'h2, 8'hC3);
        op(2'h1, 8'h00, 1'b1, 1'b0);
        idle;
        repeat (4) @(posedge clk);
        chk({6'h00, pins.sck_oe, pins.sdo_oe}, 8'h00);
        op(2'h1, 8'h31, 1'b1, 1'b0);
        idle;
        repeat (4) @(posedge clk);
        chk({6'h00, pins.sck_oe, pins.sck_o}, 8'h03);
        finish_test;
    end
endmodule
